// ### logic/csq_pkg.sv
/*
 * Package for the chip-select option qualifier: option field layout,
 * encodings, cycle-count constants and the carrier structs.
 * Assumes a single 125 MHz system clock domain.
 */
`default_nettype none
package csq_pkg;
    // Option-setting word field positions
    localparam int CSQ_MODE_BIT = 15;
    localparam int CSQ_BYTE_HI = 14;
    localparam int CSQ_BYTE_LO = 13;
    localparam int CSQ_RW_HI = 12;
    localparam int CSQ_RW_LO = 11;
    localparam int CSQ_STROBE_TIMING_SELECT_BIT = 10;
    localparam int CSQ_ACK_HI = 9;
    localparam int CSQ_ACK_LO = 6;
    localparam int CSQ_SPACE_HI = 5;
    localparam int CSQ_SPACE_LO = 4;
    localparam int CSQ_IPL_HI = 3;
    localparam int CSQ_IPL_LO = 1;
    localparam int CSQ_AUTOVECTOR_ENABLE_BIT = 0;

    // Field encodings
    localparam logic [1:0] CSQ_LANE_OFF = 2'h0;
    localparam logic [1:0] CSQ_LANE_LOW = 2'h1;
    localparam logic [1:0] CSQ_LANE_UP = 2'h2;
    localparam logic [1:0] CSQ_LANE_BOTH = 2'h3;
    localparam logic [1:0] CSQ_RW_OFF = 2'h0;
    localparam logic [1:0] CSQ_RW_READ = 2'h1;
    localparam logic [1:0] CSQ_RW_WRITE = 2'h2;
    localparam logic [1:0] CSQ_RW_BOTH = 2'h3;
    localparam logic [1:0] CSQ_SP_CPU = 2'h0;
    localparam logic [1:0] CSQ_SP_USER = 2'h1;
    localparam logic [1:0] CSQ_SP_SUPV = 2'h2;
    localparam logic [1:0] CSQ_SP_BOTH = 2'h3;
    localparam logic [2:0] CSQ_IPL_ANY = 3'h0;
    localparam logic [3:0] CSQ_ACK_FAST = 4'he;
    localparam logic [3:0] CSQ_ACK_EXT = 4'hf;
    localparam logic [1:0] CSQ_PA_CS16 = 2'h3;

    // Access timing: zero-wait access and fast termination, in clocks
    localparam logic [4:0] CSQ_BASE_CYCLES = 5'h03;
    localparam logic [4:0] CSQ_FAST_CYCLES = 5'h02;

    // Block compare: highest compared address bit, top of the bus address
    localparam int CSQ_ADDR_TOP = 23;

    // Function-code value for CPU space (interrupt acknowledge)
    localparam logic [2:0] CSQ_FC_CPU = 3'h7;
    localparam logic [2:0] CSQ_FC_SUPV_BIT = 3'h4;

    // Bus cycle as seen by the qualifier
    typedef struct packed {
        logic [23:0] addr;
        logic [2:0] fc;
        logic read;
        logic as_n;
        logic ds_n;
        logic upper_n;
        logic lower_n;
        logic iack;
    } csq_cycle_t;

    // Base-address register contents
    typedef struct packed {
        logic [12:0] base;
        logic [2:0] blk;
    } csq_base_t;

    typedef enum logic [1:0] {
        CSQ_IDLE = 2'b00,
        CSQ_COUNT = 2'b01,
        CSQ_ACK = 2'b11,
        CSQ_HOLD = 2'b10
    } csq_state_t;
endpackage
`default_nettype wire

// ### logic/csq_qualifier.sv
/*
 * Chip-select option qualifier: decides when one programmable chip
 * select asserts, generates its internal cycle acknowledge and the
 * autovector request, and flags synchronous slow-clock cycles.
 * Assumes bus cycle inputs arrive from pins (synchronised here) and
 * option/base settings are quasi-static inputs from the same clock.
 */
// Summary of operation
// - Byte-lane option 00 off, 01 lower, 10 upper, 11 both bytes.
// - Direction option 00 off, 01 reads, 10 writes, 11 both.
// - Async mode strobe select 0 follows address strobe, 1 data strobe.
// - Ack codes 0-13 ack internally after three plus code clocks.
// - Ack code 1110 is fast termination in two clocks.
// - Ack code 1111 leaves termination to the external device.
// - Space 00 CPU, 01 user, 10 supervisor, 11 either; iack in CPU only.
// - In CPU space compare irq level on address 3:1 with level field.
// - Level field 000 matches any level, 1-7 match that level.
// - Level field gates chip select, internal ack and autovector, never core interrupts.
// - CPU space plus autovector bit makes this block request autovector, in async mode only.
// - Sync mode ignores ack field; match flags pending slow-clock cycle.
// - Byte-lane option applies only for a 16-bit chip-select pin.
// - Address compare uses upper bits chosen by the block-size code.
`timescale 1ns/100ps
`default_nettype none
module csq_qualifier #(
    parameter int ADDR_W = 24 // Bus address width
) (
    input wire logic core_clk_in, // System clock, 125 MHz
    input wire logic rst_n_in, // Async reset, active low
    input wire csq_pkg::csq_cycle_t cycle_in, // Bus cycle signals from pins
    input wire logic [15:0] cs_option_setting_in, // Option word
    input wire csq_pkg::csq_base_t base_in, // Base address and block size
    input wire logic [1:0] pin_assign_in, // Pin assignment field
    output logic cs_n_out, // Chip select, active low
    output logic int_ack_n_out, // Internal cycle acknowledge, active low
    output logic autovec_n_out, // Autovector request, active low
    output logic slow_cycle_pend_out // Slow peripheral clock cycle pending
);
    import csq_pkg::*;

    // Elaboration check: field positions and block sizes assume a 24-bit bus address
    if (ADDR_W != CSQ_ADDR_TOP + 1) begin : g_addr_w_chk
        $error("csq_qualifier supports only a 24-bit address");
    end

    // Pin inputs pass two flops; stage one is read only by stage two
    csq_cycle_t sync1_r;
    csq_cycle_t cyc_r;
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_r <= '{default: 1'b1, addr: 24'h000000, fc: 3'h0, read: 1'b1};
            cyc_r <= '{default: 1'b1, addr: 24'h000000, fc: 3'h0, read: 1'b1};
        end else begin
            sync1_r <= cycle_in;
            cyc_r <= sync1_r;
        end
    end

    // Option fields
    wire logic sync_mode = cs_option_setting_in[CSQ_MODE_BIT];
    wire logic [1:0] lane_opt = cs_option_setting_in[CSQ_BYTE_HI:CSQ_BYTE_LO];
    wire logic [1:0] rw_opt = cs_option_setting_in[CSQ_RW_HI:CSQ_RW_LO];
    wire logic strobe_timing_select = cs_option_setting_in[CSQ_STROBE_TIMING_SELECT_BIT];
    wire logic [3:0] cycle_ack_source = cs_option_setting_in[CSQ_ACK_HI:CSQ_ACK_LO];
    wire logic [1:0] space_opt = cs_option_setting_in[CSQ_SPACE_HI:CSQ_SPACE_LO];
    wire logic [2:0] irq_level_match = cs_option_setting_in[CSQ_IPL_HI:CSQ_IPL_LO];
    wire logic autovector_enable = cs_option_setting_in[CSQ_AUTOVECTOR_ENABLE_BIT];

    // Number of low address bits excluded for a block-size code
    function automatic logic [4:0] blk_low_bit(input logic [2:0] code);
        case (code)
            3'h0: blk_low_bit = 5'h0b;
            3'h1: blk_low_bit = 5'h0d;
            3'h2: blk_low_bit = 5'h0e;
            3'h3: blk_low_bit = 5'h10;
            3'h4: blk_low_bit = 5'h11;
            3'h5: blk_low_bit = 5'h12;
            3'h6: blk_low_bit = 5'h13;
            default: blk_low_bit = 5'h14;
        endcase
    endfunction

    // Address compare over the selected upper bits only
    wire logic [4:0] low_bit = blk_low_bit(base_in.blk);
    wire logic [23:0] base_full = {base_in.base, 11'h000};
    wire logic [23:0] cmp_mask = 24'hffffff << low_bit;
    wire logic addr_hit = ((cyc_r.addr ^ base_full) & cmp_mask) == 24'h000000;

    // Direction qualifier
    wire logic rw_ok = (rw_opt == CSQ_RW_BOTH) ||
                       (rw_opt == CSQ_RW_READ && cyc_r.read) ||
                       (rw_opt == CSQ_RW_WRITE && !cyc_r.read);

    // Byte lanes only matter on a 16-bit chip-select pin
    wire logic port16 = (pin_assign_in == CSQ_PA_CS16);
    wire logic lane_hit = (lane_opt == CSQ_LANE_BOTH) ||
                          (lane_opt == CSQ_LANE_LOW && !cyc_r.lower_n) ||
                          (lane_opt == CSQ_LANE_UP && !cyc_r.upper_n);
    wire logic lane_ok = port16 ? lane_hit : 1'b1;

    // Address space; interrupt acknowledge exists only in CPU space
    wire logic cpu_sp = (cyc_r.fc == CSQ_FC_CPU);
    wire logic supv_sp = ((cyc_r.fc & CSQ_FC_SUPV_BIT) != 3'h0) && !cpu_sp;
    wire logic user_sp = ((cyc_r.fc & CSQ_FC_SUPV_BIT) == 3'h0);
    wire logic space_ok = (space_opt == CSQ_SP_CPU && cpu_sp && !cyc_r.iack) ||
                          (space_opt == CSQ_SP_CPU && cpu_sp && cyc_r.iack) ||
                          (space_opt == CSQ_SP_USER && user_sp) ||
                          (space_opt == CSQ_SP_SUPV && supv_sp) ||
                          (space_opt == CSQ_SP_BOTH && (user_sp || supv_sp));

    // Level compare on address 3:1, 000 is a wildcard; local only
    wire logic iack_cyc = cyc_r.iack && cpu_sp && (space_opt == CSQ_SP_CPU);
    wire logic level_ok = !iack_cyc || (irq_level_match == CSQ_IPL_ANY) ||
                          (irq_level_match == cyc_r.addr[3:1]);

    // All qualifiers at once; iack cycles skip the address compare
    wire logic addr_ok = iack_cyc ? 1'b1 : addr_hit;
    wire logic full_match = addr_ok && rw_ok && lane_ok && space_ok && level_ok;

    // Strobe timing in async mode
    wire logic strobe_on = strobe_timing_select ? !cyc_r.ds_n : !cyc_r.as_n;
    wire logic async_sel = !sync_mode && full_match && strobe_on;
    wire logic sync_sel = sync_mode && full_match && !cyc_r.as_n;
    wire logic cycle_end = cyc_r.as_n;

    // Acknowledge length: three plus code, or two for fast termination
    wire logic ack_internal = !sync_mode && (cycle_ack_source != CSQ_ACK_EXT);
    wire logic [4:0] ack_len = (cycle_ack_source == CSQ_ACK_FAST) ? CSQ_FAST_CYCLES :
                               CSQ_BASE_CYCLES + {1'b0, cycle_ack_source};

    // Wait-state counter: ack goes out on the last clock of the access
    csq_state_t state_r, state_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            CSQ_IDLE: begin
                if (async_sel && ack_internal) begin
                    cnt_nxt = ack_len - 5'h02;
                    state_nxt = (ack_len == CSQ_FAST_CYCLES) ? CSQ_ACK : CSQ_COUNT;
                end
            end
            CSQ_COUNT: begin
                if (cycle_end) begin
                    state_nxt = CSQ_IDLE;
                end else if (cnt_r <= 5'h01) begin
                    state_nxt = CSQ_ACK;
                end else begin
                    cnt_nxt = cnt_r - 5'h01;
                end
            end
            CSQ_ACK: begin
                state_nxt = CSQ_HOLD;
            end
            CSQ_HOLD: begin
                if (cycle_end) begin
                    state_nxt = CSQ_IDLE;
                end
            end
            default: begin
                state_nxt = CSQ_IDLE;
            end
        endcase
    end

    // Registered state and outputs
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= CSQ_IDLE;
            cnt_r <= 5'h00;
            cs_n_out <= 1'b1;
            int_ack_n_out <= 1'b1;
            autovec_n_out <= 1'b1;
            slow_cycle_pend_out <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            cs_n_out <= !(async_sel || sync_sel);
            int_ack_n_out <= !(state_nxt == CSQ_ACK || state_nxt == CSQ_HOLD);
            autovec_n_out <= !(async_sel && iack_cyc && autovector_enable);
            slow_cycle_pend_out <= sync_sel;
        end
    end
endmodule // csq_qualifier
`default_nettype wire

// ### tb/csq_qualifier_asserts.sv
/* Port-level checker for csq_qualifier.
   Assumes one clock domain and option changes only while the bus is idle. */
`timescale 1ns/100ps
`default_nettype none
module csq_qualifier_asserts (
    input wire logic core_clk_in, // Clock
    input wire logic rst_n_in, // Reset, active low
    input wire csq_pkg::csq_cycle_t cycle_in, // Bus cycle
    input wire logic [15:0] cs_option_setting_in, // Option word
    input wire csq_pkg::csq_base_t base_in, // Base and size
    input wire logic [1:0] pin_assign_in, // Pin assignment
    input wire logic cs_n_out, // Chip select
    input wire logic int_ack_n_out, // Internal ack
    input wire logic autovec_n_out, // Autovector request
    input wire logic slow_cycle_pend_out // Slow cycle flag
);
    import csq_pkg::*;
    wire logic [15:0] o;
    // Short alias keeps the properties on few lines
    assign o = cs_option_setting_in;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_lane_off; (o[14:13] == CSQ_LANE_OFF && pin_assign_in == CSQ_PA_CS16) |-> cs_n_out; endproperty
    a_lane_off: assert property (p_lane_off) else $error("lane off but selected");
    property p_dir_off; o[12:11] == CSQ_RW_OFF |-> cs_n_out; endproperty
    a_dir_off: assert property (p_dir_off) else $error("direction off but selected");
    property p_cs_cause; $fell(cs_n_out) |-> !$past(cycle_in.as_n, 3); endproperty
    a_cs_cause: assert property (p_cs_cause) else $error("select without strobe");
    property p_cs_release; $rose(cycle_in.as_n) |-> ##3 cs_n_out; endproperty
    a_cs_release: assert property (p_cs_release) else $error("select not released");
    property p_ack_ext; (o[9:6] == CSQ_ACK_EXT || o[CSQ_MODE_BIT]) |-> int_ack_n_out; endproperty
    a_ack_ext: assert property (p_ack_ext) else $error("internal ack not wanted");
    property p_ack_time;
        ($fell(cs_n_out) && !o[CSQ_MODE_BIT] && o[9:6] < CSQ_ACK_FAST) |-> ##[0:17] !int_ack_n_out;
    endproperty
    a_ack_time: assert property (p_ack_time) else $error("internal ack late");
    property p_fast;
        ($fell(cs_n_out) && !o[CSQ_MODE_BIT] && o[9:6] == CSQ_ACK_FAST) |-> !int_ack_n_out;
    endproperty
    a_fast: assert property (p_fast) else $error("fast termination ack late");
    property p_autovector_enable; !autovec_n_out |-> (o[5:4] == CSQ_SP_CPU && o[CSQ_AUTOVECTOR_ENABLE_BIT]); endproperty
    a_autovector_enable: assert property (p_autovector_enable) else $error("autovector not enabled");
    property p_slow; slow_cycle_pend_out |-> o[CSQ_MODE_BIT]; endproperty
    a_slow: assert property (p_slow) else $error("slow flag in async mode");
    property p_level;
        (!cs_n_out && o[5:4] == CSQ_SP_CPU && o[3:1] != CSQ_IPL_ANY) |-> $past(cycle_in.addr[3:1], 3) == o[3:1];
    endproperty
    a_level: assert property (p_level) else $error("level mismatch selected");
endmodule // csq_qualifier_asserts
bind csq_qualifier csq_qualifier_asserts u_chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .cycle_in(cycle_in), .cs_option_setting_in(cs_option_setting_in), .base_in(base_in),
    .pin_assign_in(pin_assign_in), .cs_n_out(cs_n_out), .int_ack_n_out(int_ack_n_out),
    .autovec_n_out(autovec_n_out), .slow_cycle_pend_out(slow_cycle_pend_out));
`default_nettype wire

// ### tb/csq_ext_device.sv
/* Model of a slow external device that ends its own cycles.
   Assumes the block's clock and chip select. */
`timescale 1ns/100ps
`default_nettype none
module csq_ext_device (
    input wire logic core_clk_in, // Clock
    input wire logic cs_n_in, // Chip select from block
    input wire logic ext_term_in, // Device owns termination
    output logic ext_ack_n_out // Device cycle ack, active low
);
    logic [1:0] dly_r;
    // Acks three clocks after select; slow on purpose, never before select
    always_ff @(posedge core_clk_in) begin
        if (cs_n_in || !ext_term_in) dly_r <= 2'h0;
        else if (dly_r != 2'h3) dly_r <= dly_r + 2'h1;
    end
    assign ext_ack_n_out = (dly_r != 2'h3);
endmodule // csq_ext_device
`default_nettype wire

// ### tb/csq_qualifier_bench.sv
/* Self-checking bench for csq_qualifier.
   Assumes csq_pkg, the checker and the device model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module csq_qualifier_bench;
    import csq_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    csq_cycle_t cyc = '{24'h0, 3'h5, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [15:0] opt = 16'h7830; // Both lanes, both directions, code 0, either space
    csq_base_t base = '{13'h0, 3'h0};
    logic [1:0] pa = 2'h3;
    logic cs_n, ack_n, autovector_enable_n, slow, ext_ack_n, s, av, ea, sf;
    logic ds_hold = 1'b0;
    int n_mismatch = 0;
    int checked = 0;
    int l, l0;
    csq_qualifier dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cycle_in(cyc),
        .cs_option_setting_in(opt), .base_in(base), .pin_assign_in(pa), .cs_n_out(cs_n),
        .int_ack_n_out(ack_n), .autovec_n_out(autovector_enable_n), .slow_cycle_pend_out(slow));
    csq_ext_device ext (.core_clk_in(core_clk_in), .cs_n_in(cs_n),
        .ext_term_in(opt[9:6] == 4'hf), .ext_ack_n_out(ext_ack_n));
    initial forever #4 core_clk_in = ~core_clk_in;
    task automatic chk(input logic ok);
        checked++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t unexpected port value", $time);
        end
    endtask
    // One bus cycle; strobe held a fixed 24 clocks so slow acks still land
    task automatic bus(input logic [15:0] op, input logic [23:0] a, input logic [2:0] f);
        @(negedge core_clk_in);
        opt = op;
        cyc.addr = a;
        cyc.fc = f;
        cyc.iack = (f == CSQ_FC_CPU);
        {s, av, ea, sf, l} = {4'h0, -32'sd1};
        repeat (2) @(negedge core_clk_in);
        cyc.as_n = 1'b0;
        cyc.ds_n = ds_hold;
        for (int i = 0; i < 24; i++) begin
            @(negedge core_clk_in);
            if (cs_n === 1'b0) s = 1'b1;
            if (autovector_enable_n === 1'b0) av = 1'b1;
            if (ext_ack_n === 1'b0) ea = 1'b1;
            if (slow === 1'b1) sf = 1'b1;
            if (l < 0 && ack_n === 1'b0) l = i;
        end
        cyc.as_n = 1'b1;
        cyc.ds_n = 1'b1;
        repeat (6) @(negedge core_clk_in);
    endtask
    task automatic t_lane_dir();
        for (int k = 0; k < 4; k++) begin
            bus({1'b0, k[1:0], 13'h1830}, 24'h000100, 3'h5);
            chk(s === k[1]);
            bus({3'h3, k[1:0], 11'h030}, 24'h000100, 3'h5);
            chk(s === k[0]);
        end
        cyc.read = 1'b0;
        bus(16'h7030, 24'h000100, 3'h5);
        chk(s === 1'b1);
        cyc.read = 1'b1;
        pa = 2'h2;
        bus(16'h1830, 24'h000100, 3'h5);
        chk(s === 1'b1);
        pa = 2'h3;
    endtask
    task automatic t_space_addr();
        for (int k = 1; k < 4; k++) begin
            bus({10'h1e0, k[1:0], 4'h0}, 24'h000100, 3'h1);
            chk(s === (k != 2));
        end
        bus(16'h7830, 24'h001000, 3'h5);
        chk(s === 1'b0);
        base.blk = 3'h1;
        bus(16'h7830, 24'h001000, 3'h5);
        chk(s === 1'b1);
        base.blk = 3'h0;
    endtask
    task automatic t_iack();
        bus({10'h1e0, 2'h0, 3'h3, 1'b1}, 24'h000006, CSQ_FC_CPU);
        chk(s === 1'b1 && av === 1'b1);
        bus({10'h1e0, 2'h0, 3'h3, 1'b1}, 24'h000008, CSQ_FC_CPU);
        chk(s === 1'b0 && av === 1'b0);
        bus({10'h1e0, 6'h0}, 24'h00000a, CSQ_FC_CPU);
        chk(s === 1'b1 && av === 1'b0);
    endtask
    task automatic t_ack_mode();
        bus({6'h1e, 4'h0, 6'h30}, 24'h000100, 3'h5);
        l0 = l;
        chk(l0 >= 0);
        for (int c = 1; c < 16; c++) begin
            bus({6'h1e, c[3:0], 6'h30}, 24'h000100, 3'h5);
            if (c < 14) chk(l == l0 + c);
            if (c == 14) chk(l == l0 - 1);
            if (c == 15) chk(l < 0 && ea === 1'b1);
        end
        bus(16'hf830, 24'h000100, 3'h5);
        chk(sf === 1'b1 && l < 0);
        ds_hold = 1'b1;
        bus({5'h0f, 1'b1, 10'h030}, 24'h000100, 3'h5);
        chk(s === 1'b0);
        bus({5'h0f, 1'b0, 10'h030}, 24'h000100, 3'h5);
        chk(s === 1'b1);
        ds_hold = 1'b0;
        bus({5'h0f, 1'b1, 10'h030}, 24'h000100, 3'h5);
        chk(s === 1'b1);
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Main sequence: reset, then each scenario in turn
    initial begin
        repeat (2) @(negedge core_clk_in);
        chk(cs_n === 1'b1 && ack_n === 1'b1 && autovector_enable_n === 1'b1 && slow === 1'b0);
        rst_n_in = 1'b1;
        t_lane_dir();
        t_space_addr();
        t_iack();
        t_ack_mode();
        report_and_stop();
    end
endmodule // csq_qualifier_bench
`default_nettype wire
